// [rtl/aofc_output_format.sv]
// Serially programmed output format control with data formatting path
`timescale 1ns/100ps
`default_nettype none
`include "aofc_defs.svh"
module aofc_output_format (
    input wire logic clk,
    input wire logic reset,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_sdi,
    output logic spi_sdo_out,
    output logic spi_sdo_oe_n,
    input wire logic [15:0] conv_data,
    input wire logic conv_valid,
    output logic [15:0] output_data_bits,
    output logic output_data_valid,
    output logic output_data_oe_n,
    output logic [1:0] output_mode_sel,
    output logic [2:0] lvds_drive_current_sel,
    output logic internal_termination_on,
    output logic randomizer_en,
    output logic alternate_polarity_en,
    output logic twos_complement_en
);
    // ****************************************
    // Helpers
    // ****************************************
    // Read back value of an address; write-only and unmapped read zero
    function automatic logic [7:0] read_value(input logic [6:0] addr,
                                              input logic [7:0] om,
                                              input logic [7:0] fm);
        read_value = `AOFC_REG_RESET;
        if (addr == `AOFC_ADDR_OUTMODE) begin
            read_value = om;
        end else if (addr == `AOFC_ADDR_FORMAT) begin
            read_value = fm;
        end
    endfunction

    // Converts one conversion word to the output word
    function automatic logic [15:0] format_word(input logic [15:0] din,
                                                input aofc_pkg::aofc_format_t f,
                                                input logic phase);
        logic [15:0] w;
        logic [15:0] pat;
        w = din;
        pat = `AOFC_WORD_ZERO;
        // Twos complement only when polarity mode is off
        if (f.twos_complement && !f.alternate_polarity) begin
            w[`AOFC_MSB] = ~w[`AOFC_MSB];
        end
        // Randomizer folds bit 0 into the upper bits
        if (f.randomizer) begin
            w[15:1] = w[15:1] ^ {15{w[0]}};
        end
        // Every other bit inverted
        if (f.alternate_polarity) begin
            w = w ^ `AOFC_ABP_MASK;
        end
        // Pattern selection; unlisted codes behave as off
        case (f.test_pattern)
            `AOFC_TP_ZERO: pat = `AOFC_WORD_ZERO;
            `AOFC_TP_ONE: pat = `AOFC_WORD_ONE;
            `AOFC_TP_CHECK: pat = phase ? ~`AOFC_WORD_CHECK : `AOFC_WORD_CHECK;
            `AOFC_TP_ALT: pat = phase ? `AOFC_WORD_ONE : `AOFC_WORD_ZERO;
            default: pat = w;
        endcase
        // Low two bits stay with the data path
        format_word = (pat & `AOFC_PATTERN_MASK) | (w & ~`AOFC_PATTERN_MASK);
    endfunction

    // ****************************************
    // Serial port state
    // ****************************************
    aofc_pkg::aofc_spi_state_t state; // Frame state
    aofc_pkg::aofc_spi_state_t next_state;
    logic sck_q; // Previous clock pin level
    logic [4:0] bit_cnt; // Bits taken in this frame
    logic [4:0] next_bit_cnt;
    logic [15:0] shift_in; // Received frame bits
    logic [15:0] next_shift_in;
    logic [7:0] rd_shift; // Read back data
    logic [7:0] next_rd_shift;
    logic next_sdo_oe_n;
    logic rd_frame; // Frame in progress is a read
    logic next_rd_frame;
    logic sck_rise; // Rising edge seen this cycle
    logic [15:0] frame; // Frame including this cycle's bit

    // Register file
    aofc_pkg::aofc_outmode_t outmode_reg; // Output mode register
    aofc_pkg::aofc_outmode_t next_outmode_reg;
    aofc_pkg::aofc_format_t format_reg; // Data format register
    aofc_pkg::aofc_format_t next_format_reg;

    assign sck_rise = spi_sck && !sck_q;
    assign frame = {shift_in[14:0], spi_sdi};
    assign spi_sdo_out = 1'b0; // Open drain only pulls low

    // ****************************************
    // Serial port and register next values
    // ****************************************
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_rd_shift = rd_shift;
        next_outmode_reg = outmode_reg;
        next_format_reg = format_reg;
        next_rd_frame = rd_frame;
        if (spi_cs_n) begin
            // Deselect ends or aborts the frame
            next_state = aofc_pkg::AOFC_IDLE;
            next_bit_cnt = `AOFC_CNT_ZERO;
        end else if (state != aofc_pkg::AOFC_HOLD && sck_rise) begin
            // Take one bit, MSB first
            next_state = aofc_pkg::AOFC_SHIFT;
            next_shift_in = frame;
            next_bit_cnt = bit_cnt + `AOFC_CNT_ONE;
            next_rd_frame = (bit_cnt == `AOFC_CNT_ZERO) ? spi_sdi : rd_frame;
            if (bit_cnt == `AOFC_HDR_LAST) begin
                // Header complete: fetch read data
                next_rd_shift = read_value(frame[6:0], outmode_reg, format_reg);
            end else if (bit_cnt > `AOFC_HDR_LAST) begin
                next_rd_shift = {rd_shift[6:0], 1'b0};
            end
            if (bit_cnt == `AOFC_FRAME_LAST) begin
                next_state = aofc_pkg::AOFC_HOLD;
                // Read frames never update registers
                if (!frame[`AOFC_RW_BIT]) begin
                    case (frame[`AOFC_ADDR_HI:`AOFC_ADDR_LO])
                        `AOFC_ADDR_RESET: begin
                            if (frame[`AOFC_SWRST_BIT]) begin
                                next_outmode_reg = `AOFC_REG_RESET;
                                next_format_reg = `AOFC_REG_RESET;
                            end
                        end
                        `AOFC_ADDR_OUTMODE: begin
                            // Mode 11 stored as written; host keeps it out
                            next_outmode_reg = frame[7:0] & `AOFC_OUTMODE_MASK;
                        end
                        `AOFC_ADDR_FORMAT: begin
                            next_format_reg = frame[7:0] & `AOFC_FORMAT_MASK;
                        end
                        default: begin
                            next_state = aofc_pkg::AOFC_HOLD;
                        end
                    endcase
                end
            end
        end
        // Pull SDO low for a zero read bit during the data phase
        next_sdo_oe_n = !(!spi_cs_n && next_rd_frame && next_bit_cnt > `AOFC_HDR_LAST
                          && next_state == aofc_pkg::AOFC_SHIFT && !next_rd_shift[7]);
    end

    // Registers the serial port and register file
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= aofc_pkg::AOFC_IDLE;
            sck_q <= 1'b0;
            bit_cnt <= `AOFC_CNT_ZERO;
            shift_in <= `AOFC_WORD_ZERO;
            rd_shift <= `AOFC_REG_RESET;
            rd_frame <= 1'b0;
            spi_sdo_oe_n <= 1'b1;
            outmode_reg <= `AOFC_REG_RESET;
            format_reg <= `AOFC_REG_RESET;
        end else begin
            state <= next_state;
            sck_q <= spi_sck;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            rd_shift <= next_rd_shift;
            rd_frame <= next_rd_frame;
            spi_sdo_oe_n <= next_sdo_oe_n;
            outmode_reg <= next_outmode_reg;
            format_reg <= next_format_reg;
        end
    end

    // ****************************************
    // Configuration outputs
    // ****************************************
    assign output_mode_sel = outmode_reg.output_mode;
    assign lvds_drive_current_sel = outmode_reg.drive_current;
    assign internal_termination_on = outmode_reg.termination_on;
    assign output_data_oe_n = outmode_reg.output_disable;
    assign randomizer_en = format_reg.randomizer;
    assign alternate_polarity_en = format_reg.alternate_polarity;
    assign twos_complement_en = format_reg.twos_complement;

    // ****************************************
    // Data path
    // ****************************************
    logic phase; // Alternation phase of patterns
    logic next_phase;
    logic [15:0] next_output_data_bits;
    logic next_output_data_valid;

    // Formats one word per valid input
    always_comb begin
        next_phase = phase;
        next_output_data_bits = output_data_bits;
        next_output_data_valid = conv_valid;
        if (conv_valid) begin
            next_output_data_bits = format_word(conv_data, format_reg, phase);
            next_phase = !phase;
        end
    end

    // Registers the output word
    always_ff @(posedge clk) begin
        if (reset) begin
            phase <= 1'b0;
            output_data_bits <= `AOFC_WORD_ZERO;
            output_data_valid <= 1'b0;
        end else begin
            phase <= next_phase;
            output_data_bits <= next_output_data_bits;
            output_data_valid <= next_output_data_valid;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_ZERO_PATTERN: assert property (
        conv_valid && format_reg.test_pattern == `AOFC_TP_ZERO
        |=> output_data_bits[15:2] == 14'h0000) else $error("zero pattern wrong");
    AST_ONE_PATTERN: assert property (
        conv_valid && format_reg.test_pattern == `AOFC_TP_ONE
        |=> output_data_bits[15:2] == 14'h3FFF) else $error("one pattern wrong");
    AST_CHECK_ALT: assert property (
        conv_valid && format_reg.test_pattern == `AOFC_TP_CHECK
        ##1 conv_valid && $stable(format_reg)
        |=> output_data_bits[15:2] == ~$past(output_data_bits[15:2])) else $error("checker wrong");
    AST_ALT_WORDS: assert property (
        conv_valid && format_reg.test_pattern == `AOFC_TP_ALT
        |=> output_data_bits[15:2] == {14{$past(phase)}}) else $error("alternating pattern wrong");
    AST_LOW_BITS: assert property (
        conv_valid && format_reg.test_pattern != `AOFC_TP_OFF
        && !format_reg.randomizer && !format_reg.alternate_polarity
        |=> output_data_bits[1:0] == $past(conv_data[1:0])) else $error("low bits forced");
    AST_PASS_DATA: assert property (
        conv_valid && format_reg == `AOFC_REG_RESET
        |=> output_data_bits == $past(conv_data)) else $error("normal data altered");
    AST_ABP_OFFSET: assert property (
        conv_valid && format_reg.test_pattern == `AOFC_TP_OFF
        && format_reg.alternate_polarity && !format_reg.randomizer
        |=> output_data_bits == ($past(conv_data) ^ `AOFC_ABP_MASK)) else $error("polarity wrong");
    AST_TWOS: assert property (
        conv_valid && format_reg.test_pattern == `AOFC_TP_OFF && format_reg.twos_complement
        && !format_reg.alternate_polarity && !format_reg.randomizer
        |=> output_data_bits[15] == !$past(conv_data[15])) else $error("format wrong");
    AST_UNUSED_BITS: assert property (
        !outmode_reg.unused && format_reg.unused == 2'h0) else $error("unused bit stored");
    AST_SW_RESET: assert property (
        !spi_cs_n && sck_rise && bit_cnt == `AOFC_FRAME_LAST && state != aofc_pkg::AOFC_HOLD
        && frame[15:8] == 8'h00 && frame[`AOFC_SWRST_BIT]
        |=> outmode_reg == `AOFC_REG_RESET && format_reg == `AOFC_REG_RESET)
        else $error("software reset missed");
    AST_DISABLE: assert property (
        !spi_cs_n && sck_rise && bit_cnt == `AOFC_FRAME_LAST && state != aofc_pkg::AOFC_HOLD
        && frame[15:8] == {1'b0, `AOFC_ADDR_OUTMODE}
        |=> output_data_oe_n == $past(frame[`AOFC_OUTPUT_DISABLE_BIT])) else $error("output disable wrong");

    COV_WRITE_MODE: cover property (outmode_reg.output_mode == `AOFC_OM_DDR_LVDS);
    COV_CHECKER: cover property (conv_valid && format_reg.test_pattern == `AOFC_TP_CHECK);
    COV_READ: cover property (!spi_sdo_oe_n);
    COV_DISABLED: cover property (outmode_reg.output_disable && conv_valid);
endmodule // aofc_output_format
`default_nettype wire

// [include/aofc_defs.svh]
// Constants for the output format control block: addresses, fields, codes, patterns
`ifndef AOFC_DEFS_SVH
`define AOFC_DEFS_SVH
// ****************************************
// Serial frame layout
// ****************************************
`define AOFC_FRAME_LAST 5'h0F
`define AOFC_HDR_LAST 5'h07
`define AOFC_CNT_ONE 5'h01
`define AOFC_CNT_ZERO 5'h00
`define AOFC_RW_BIT 15
`define AOFC_ADDR_HI 14
`define AOFC_ADDR_LO 8
// ****************************************
// Register addresses
// ****************************************
`define AOFC_ADDR_RESET 7'h00
`define AOFC_ADDR_OUTMODE 7'h03
`define AOFC_ADDR_FORMAT 7'h04
`define AOFC_SWRST_BIT 7
`define AOFC_OUTPUT_DISABLE_BIT 2
// ****************************************
// Reset values and writable bit masks
// ****************************************
`define AOFC_REG_RESET 8'h00
`define AOFC_OUTMODE_MASK 8'h7F
`define AOFC_FORMAT_MASK 8'h3F
// ****************************************
// Output mode codes
// ****************************************
`define AOFC_OM_CMOS 2'h0
`define AOFC_OM_DDR_LVDS 2'h1
`define AOFC_OM_DDR_CMOS 2'h2
// ****************************************
// Test pattern codes and words
// ****************************************
`define AOFC_TP_OFF 3'h0
`define AOFC_TP_ZERO 3'h1
`define AOFC_TP_ONE 3'h3
`define AOFC_TP_CHECK 3'h5
`define AOFC_TP_ALT 3'h7
`define AOFC_WORD_ZERO 16'h0000
`define AOFC_WORD_ONE 16'hFFFF
`define AOFC_WORD_CHECK 16'h5555
`define AOFC_PATTERN_MASK 16'hFFFC
`define AOFC_ABP_MASK 16'hAAAA
`define AOFC_MSB 15
`endif

// [include/aofc_pkg.sv]
// Types shared by the output format control block
package aofc_pkg;
    // Output mode register layout
    typedef struct packed {
        logic unused;                 // Ignored bit
        logic [2:0] drive_current;    // LVDS drive current select
        logic termination_on;         // Internal termination
        logic output_disable;         // Outputs high impedance
        logic [1:0] output_mode;      // Output mode select
    } aofc_outmode_t;
    // Data format register layout
    typedef struct packed {
        logic [1:0] unused;           // Ignored bits
        logic [2:0] test_pattern;     // Test pattern select
        logic alternate_polarity;     // Alternate bit polarity
        logic randomizer;             // Randomizer enable
        logic twos_complement;        // Format select
    } aofc_format_t;
    // Serial port states, Gray ordered
    typedef enum logic [1:0] {
        AOFC_IDLE = 2'b00,
        AOFC_SHIFT = 2'b01,
        AOFC_HOLD = 2'b11
    } aofc_spi_state_t;
endpackage

// [sim/aofc_capture.sv]
// Capture model for the logic that takes formatted words off the data pins
`timescale 1ns/100ps
`default_nettype none
module aofc_capture (
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] data_pins,
    input wire logic data_valid,
    input wire logic data_oe_n,
    input wire logic polarity_en,
    output logic [15:0] word,
    output logic [15:0] taken
);
    // Takes a word only while the pins are driven, undoing polarity inversion
    always_ff @(posedge clk) begin
        if (reset) begin
            taken <= 16'h0000;
            word <= 16'h0000;
        end else if (data_valid && !data_oe_n) begin
            word <= data_pins ^ (polarity_en ? 16'hAAAA : 16'h0000);
            taken <= taken + 16'h0001;
        end
    end
endmodule // aofc_capture
`default_nettype wire

// [sim/adc_output_format_control_test.sv]
// Self-checking bench for the output format control block
`timescale 1ns/100ps
`default_nettype none
module adc_output_format_control_test;
    // ****
    // Pins, counters and tables
    // ****
    logic clk, reset, spi_cs_n, spi_sck, spi_sdi, spi_sdo_out, spi_sdo_oe_n;
    logic [15:0] conv_data, output_data_bits, cap_word, taken, t0;
    logic conv_valid, output_data_valid, output_data_oe_n, internal_termination_on;
    logic [1:0] output_mode_sel;
    logic [2:0] lvds_drive_current_sel;
    logic randomizer_en, alternate_polarity_en, twos_complement_en, phase;
    logic [31:0] seed;
    logic [7:0] rb, fm;
    logic [15:0] expq[$];
    logic [7:0] fmt_tab[11] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h18, 8'h28,
        8'h38, 8'hC0, 8'h10};
    logic [2:0] cur_tab[7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    int mismatches, n_tests;
    aofc_output_format dut (.clk(clk), .reset(reset), .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo_out(spi_sdo_out),
        .spi_sdo_oe_n(spi_sdo_oe_n), .conv_data(conv_data), .conv_valid(conv_valid),
        .output_data_bits(output_data_bits), .output_data_valid(output_data_valid),
        .output_data_oe_n(output_data_oe_n), .output_mode_sel(output_mode_sel),
        .lvds_drive_current_sel(lvds_drive_current_sel),
        .internal_termination_on(internal_termination_on), .randomizer_en(randomizer_en),
        .alternate_polarity_en(alternate_polarity_en),
        .twos_complement_en(twos_complement_en));
    aofc_capture cap (.clk(clk), .reset(reset), .data_pins(output_data_bits),
        .data_valid(output_data_valid), .data_oe_n(output_data_oe_n),
        .polarity_en(alternate_polarity_en), .word(cap_word), .taken(taken));
    // Free-running 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Fixed-seed xorshift source of conversion words
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Expected formatted word for one conversion word
    function automatic logic [15:0] expw(input logic [15:0] d, input aofc_pkg::aofc_format_t f,
        input logic ph);
        logic [15:0] w;
        w = d;
        if (f.twos_complement && !f.alternate_polarity) w[15] = ~w[15];
        if (f.randomizer) w[15:1] = w[15:1] ^ {15{w[0]}};
        if (f.alternate_polarity) w = w ^ 16'hAAAA;
        case (f.test_pattern)
            3'h1: w[15:2] = 14'h0000;
            3'h3: w[15:2] = 14'h3FFF;
            3'h5: w[15:2] = ph ? 14'h2AAA : 14'h1555;
            3'h7: w[15:2] = ph ? 14'h3FFF : 14'h0000;
            default: w = w;
        endcase
        return w;
    endfunction
    // Compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic results;
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One serial frame of nb bits, sck half period two clocks; read bits land in rb
    task automatic frame(input logic r, input logic [6:0] a, input logic [7:0] d, input int nb);
        logic [15:0] w;
        w = {r, a, d};
        rb = 8'h00;
        spi_cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            spi_sck = 1'b0;
            spi_sdi = w[15-i];
            repeat (2) @(negedge clk);
            if (i >= 8) rb[15-i] = spi_sdo_oe_n ? 1'b1 : spi_sdo_out;
            spi_sck = 1'b1;
            repeat (2) @(negedge clk);
        end
        spi_sck = 1'b0;
        @(negedge clk);
        spi_cs_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    // Back-to-back conversion words, each expectation queued
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            conv_data = seed[15:0];
            conv_valid = 1'b1;
            expq.push_back(expw(seed[15:0], fm, phase));
            phase = ~phase;
            @(negedge clk);
        end
        conv_valid = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // Output watcher: oldest expectation against each word that appears
    always @(negedge clk) begin
        if (output_data_valid === 1'b1) begin
            if (expq.size() == 0) check("spare word", 16'h0001, 16'h0000);
            else check("output_data_bits", output_data_bits, expq.pop_front());
        end
    end
    // Watchdog against a hang
    initial begin
        #3000000;
        mismatches++;
        results();
    end
    // Main sequence
    initial begin
        {reset, spi_cs_n, spi_sck, spi_sdi, conv_valid, phase} = 6'h30;
        conv_data = 16'h0000;
        {mismatches, n_tests, seed, fm} = {32'h0, 32'h0, 32'h00000063, 8'h00};
        repeat (2) @(negedge clk);
        reset = 1'b0;
        for (int a = 3; a < 5; a++) begin
            frame(1'b1, a[6:0], 8'h00, 16);
            check("reset value", {8'h00, rb}, 16'h0000);
        end
        // Drive current codes with each output mode, never mode 11
        for (int i = 0; i < 7; i++) begin
            frame(1'b0, 7'h03, {1'b1, cur_tab[i], 2'b10, 2'(i % 3)}, 16);
            check("lvds_drive_current_sel", {13'h0, lvds_drive_current_sel}, {13'h0, cur_tab[i]});
            check("output_mode_sel", {14'h0, output_mode_sel}, 16'(i % 3));
            check("internal_termination_on", {15'h0, internal_termination_on}, 16'h0001);
            frame(1'b1, 7'h03, 8'h00, 16);
            check("output_mode_config", {8'h00, rb}, {8'h00, 1'b0, cur_tab[i], 2'b10, 2'(i % 3)});
        end
        // Partial frame and unmapped address change nothing
        frame(1'b0, 7'h03, 8'h01, 8);
        frame(1'b0, 7'h05, 8'hFF, 16);
        frame(1'b1, 7'h05, 8'h00, 16);
        check("unmapped read", {8'h00, rb}, 16'h0000);
        frame(1'b1, 7'h03, 8'h00, 16);
        check("output_mode_config", {8'h00, rb}, 16'h0078);
        // Disabled outputs: capture sees nothing
        frame(1'b0, 7'h03, 8'h04, 16);
        check("output_data_oe_n", {15'h0, output_data_oe_n}, 16'h0001);
        t0 = taken;
        send(3);
        check("words taken", taken, t0);
        frame(1'b0, 7'h03, 8'h00, 16);
        check("output_data_oe_n", {15'h0, output_data_oe_n}, 16'h0000);
        // Every defined pattern code plus code 2, and each format bit, with back-to-back words
        for (int k = 0; k < 11; k++) begin
            frame(1'b0, 7'h04, fmt_tab[k], 16);
            fm = fmt_tab[k] & 8'h3F;
            check("format fields", {13'h0, alternate_polarity_en, randomizer_en, twos_complement_en}, {13'h0, fm[2:0]});
            send(4);
            if (fm == 8'h04) check("recovered word", cap_word, conv_data);
        end
        // Reset register: bit 7 clear does nothing, set clears both
        frame(1'b0, 7'h00, 8'h7F, 16);
        frame(1'b1, 7'h04, 8'h00, 16);
        check("data_format_config", {8'h00, rb}, 16'h0010);
        frame(1'b0, 7'h00, 8'h80, 16);
        for (int a = 3; a < 5; a++) begin
            frame(1'b1, a[6:0], 8'h00, 16);
            check("cleared register", {8'h00, rb}, 16'h0000);
        end
        results();
    end
endmodule // adc_output_format_control_test
`default_nettype wire
